// ===== hw/fsp_pkg.sv
// package: register map, field layout and constants of the frame-sync pulse and channel divider
package fsp_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] FSP_IDX_CTRL = 8'h47;
    localparam logic [7:0] FSP_IDX_DIV = 8'h48;
    localparam logic [7:0] FSP_IDX_DLYA = 8'h49;
    localparam logic [7:0] FSP_IDX_DLYB = 8'h4A;
    localparam logic [7:0] FSP_IDX_OUTPUT_CHANNEL_DIVIDER_CODE = 8'h4B;
    localparam logic [7:0] FSP_IDX_STAT = 8'h4C;
    localparam logic [15:0] FSP_RST_CTRL = 16'h0080;
    localparam logic [15:0] FSP_RST_DIV = 16'h0001;
    localparam logic [15:0] FSP_RST_DLYA = 16'h003F;
    localparam logic [15:0] FSP_RST_DLYB = 16'h0000;
    localparam logic [15:0] FSP_RST_OUTPUT_CHANNEL_DIVIDER_CODE = 16'h0800;
    localparam logic [1:0] FSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] FSP_RESP_SLVERR = 2'h2;
    localparam logic [2:0] FSP_PRE_DIV2 = 3'h2;
    localparam logic [2:0] FSP_PRE_DIV4 = 3'h4;
    localparam logic [4:0] FSP_OUTPUT_CHANNEL_DIVIDER_CODE_MAX = 5'h0C;
    // control register fields
    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [2:0] frame_sync_prescaler;
        logic burst_enable;
        logic frame_sync_enable;
        logic repeater_mode_select;
        logic [1:0] rsvd_lo;
    } fsp_ctrl_t;
    typedef struct packed {
        logic [4:0] rsvd;
        logic [10:0] frame_sync_post_divider;
    } fsp_div_t;
    typedef struct packed {
        logic [3:0] rsvd;
        logic [5:0] delay_adjust_two;
        logic [5:0] delay_adjust_one;
    } fsp_dlya_t;
    typedef struct packed {
        logic [3:0] burst_pulse_count;
        logic [5:0] delay_adjust_four;
        logic [5:0] delay_adjust_three;
    } fsp_dlyb_t;
    typedef struct packed {
        logic [4:0] rsvd_hi;
        logic [4:0] output_channel_divider_code;
        logic [5:0] rsvd_lo;
    } fsp_output_channel_divider_code_t;
    typedef enum logic [2:0] {
        FSP_IDLE = 3'b001,
        FSP_RUN = 3'b010,
        FSP_BURST = 3'b100
    } fsp_state_t;
endpackage

// ===== hw/fsp_frame_sync.sv
// frame-sync pulse generator, channel divider and AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fsp_frame_sync
    import fsp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_sync_request_pin,
    input wire logic src_clk_en,
    output logic chan_clk_en,
    output logic frame_sync_pulse,
    output logic [5:0] delay_adjust_one,
    output logic [5:0] delay_adjust_two,
    output logic [5:0] delay_adjust_three,
    output logic [5:0] delay_adjust_four
);
    fsp_ctrl_t ctrl_r;
    fsp_div_t div_r;
    fsp_dlya_t dlya_r;
    fsp_dlyb_t dlyb_r;
    fsp_output_channel_divider_code_t output_channel_divider_code_r;
    logic [31:0] awaddr_r;
    logic aw_have_r;
    logic [15:0] wdata_r;
    logic [1:0] wstrb_r;
    logic w_have_r;
    logic [15:0] rdata_r;
    logic rerr_r;
    logic bvalid_r;
    logic berr_r;
    logic rvalid_r;
    logic req_s1_r;
    logic req_s2_r;
    logic req_d_r;
    logic [1:0] pre_cnt_r;
    logic [10:0] post_cnt_r;
    logic [7:0] ch_cnt_r;
    logic [3:0] burst_left_r;
    logic pulse_r;
    fsp_state_t state_r;
    fsp_state_t state_nxt;

    // address decode
    wire [7:0] w_idx = awaddr_r[9:2];
    wire w_ok = (awaddr_r[31:10] == 22'h0) && (w_idx >= FSP_IDX_CTRL) && (w_idx <= FSP_IDX_OUTPUT_CHANNEL_DIVIDER_CODE);
    wire [7:0] r_idx = s_axi_araddr[9:2];
    wire r_hi_ok = (s_axi_araddr[31:10] == 22'h0);
    wire do_write = aw_have_r && w_have_r && !bvalid_r;
    wire [15:0] wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire rd_take = s_axi_arvalid && !rvalid_r;

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = berr_r ? FSP_RESP_SLVERR : FSP_RESP_OKAY;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = {16'h0000, rdata_r};
    assign s_axi_rresp = rerr_r ? FSP_RESP_SLVERR : FSP_RESP_OKAY;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // channel ratio table: 2,4,6,8,12,16,24,32,48,64,96,128,192
    function automatic logic [7:0] ch_ratio(input logic [4:0] code);
        case (code)
            5'h00: ch_ratio = 8'h02;
            5'h01: ch_ratio = 8'h04;
            5'h02: ch_ratio = 8'h06;
            5'h03: ch_ratio = 8'h08;
            5'h04: ch_ratio = 8'h0C;
            5'h05: ch_ratio = 8'h10;
            5'h06: ch_ratio = 8'h18;
            5'h07: ch_ratio = 8'h20;
            5'h08: ch_ratio = 8'h30;
            5'h09: ch_ratio = 8'h40;
            5'h0A: ch_ratio = 8'h60;
            5'h0B: ch_ratio = 8'h80;
            5'h0C: ch_ratio = 8'hC0;
            default: ch_ratio = 8'hC0;
        endcase
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 32'h0;
            wdata_r <= 16'h0;
            wstrb_r <= 2'h0;
            bvalid_r <= 1'b0;
            berr_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata[15:0];
                wstrb_r <= s_axi_wstrb[1:0];
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                berr_r <= !w_ok;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // registers keep every bit as written, reserved ones too, so software can read back 
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= FSP_RST_CTRL;
            div_r <= FSP_RST_DIV;
            dlya_r <= FSP_RST_DLYA;
            dlyb_r <= FSP_RST_DLYB;
            output_channel_divider_code_r <= FSP_RST_OUTPUT_CHANNEL_DIVIDER_CODE;
        end else if (do_write && w_ok) begin
            case (w_idx)
                FSP_IDX_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wmask);
                FSP_IDX_DIV: div_r <= merge(div_r, wdata_r, wmask);
                FSP_IDX_DLYA: dlya_r <= merge(dlya_r, wdata_r, wmask);
                FSP_IDX_DLYB: dlyb_r <= merge(dlyb_r, wdata_r, wmask);
                FSP_IDX_OUTPUT_CHANNEL_DIVIDER_CODE: output_channel_divider_code_r <= merge(output_channel_divider_code_r, wdata_r, wmask);
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 16'h0;
            rerr_r <= 1'b0;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rerr_r <= 1'b0;
            case (r_hi_ok ? r_idx : 8'h00)
                FSP_IDX_CTRL: rdata_r <= ctrl_r;
                FSP_IDX_DIV: rdata_r <= div_r;
                FSP_IDX_DLYA: rdata_r <= dlya_r;
                FSP_IDX_DLYB: rdata_r <= dlyb_r;
                FSP_IDX_OUTPUT_CHANNEL_DIVIDER_CODE: rdata_r <= output_channel_divider_code_r;
                FSP_IDX_STAT: rdata_r <= {8'h00, 1'b0, state_r, burst_left_r};
                default: begin
                    rdata_r <= 16'h0;
                    rerr_r <= 1'b1;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // request pin crosses in through two flops; only the second is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_d_r <= 1'b0;
        end else begin
            req_s1_r <= frame_sync_request_pin;
            req_s2_r <= req_s1_r;
            req_d_r <= req_s2_r;
        end
    end
    wire req_rise = req_s2_r && !req_d_r;

    // prescaler: any code other than 2 behaves as divide by 4
    wire [1:0] pre_last = (ctrl_r.frame_sync_prescaler == FSP_PRE_DIV2) ? 2'd1 : 2'd3;
    wire pre_tick = src_clk_en && (pre_cnt_r == pre_last);
    // post divider: zero is treated as one to avoid a stall
    wire [10:0] post_last = (div_r.frame_sync_post_divider == 11'h0) ? 11'h0
                          : div_r.frame_sync_post_divider - 11'h1;
    wire post_tick = pre_tick && (post_cnt_r >= post_last);
    wire en = ctrl_r.frame_sync_enable;
    wire repeater = ctrl_r.repeater_mode_select;
    // burst start: repeater mode, or burst mode in master; pulse count applies to both
    wire burst_trig = req_rise && (repeater || ctrl_r.burst_enable);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FSP_IDLE: begin
                if (en && burst_trig) begin
                    state_nxt = FSP_BURST;
                end else if (en && !repeater && !ctrl_r.burst_enable) begin
                    state_nxt = FSP_RUN;
                end
            end
            FSP_RUN: begin
                if (!en || repeater || ctrl_r.burst_enable) begin
                    state_nxt = FSP_IDLE;
                end
            end
            FSP_BURST: begin
                if (!en || (post_tick && burst_left_r <= 4'd1)) begin
                    state_nxt = FSP_IDLE;
                end
            end
            default: state_nxt = FSP_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= FSP_IDLE;
            pre_cnt_r <= 2'd0;
            post_cnt_r <= 11'd0;
            burst_left_r <= 4'd0;
            pulse_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pulse_r <= (state_r != FSP_IDLE) && en && post_tick;
            if (state_r == FSP_IDLE) begin
                pre_cnt_r <= 2'd0;
                post_cnt_r <= 11'd0;
                // a count of zero still sends one pulse
                burst_left_r <= dlyb_r.burst_pulse_count;
            end else if (src_clk_en) begin
                pre_cnt_r <= pre_tick ? 2'd0 : pre_cnt_r + 2'd1;
                if (pre_tick) begin
                    post_cnt_r <= post_tick ? 11'd0 : post_cnt_r + 11'd1;
                end
                if (post_tick && state_r == FSP_BURST && burst_left_r != 4'd0) begin
                    burst_left_r <= burst_left_r - 4'd1;
                end
            end
        end
    end

    // channel divider; codes above 12 hold the largest ratio
    wire [7:0] ch_last = ch_ratio(output_channel_divider_code_r.output_channel_divider_code) - 8'h01;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_cnt_r <= 8'h00;
            chan_clk_en <= 1'b0;
        end else begin
            chan_clk_en <= src_clk_en && (ch_cnt_r >= ch_last);
            if (src_clk_en) begin
                ch_cnt_r <= (ch_cnt_r >= ch_last) ? 8'h00 : ch_cnt_r + 8'h01;
            end
        end
    end

    assign frame_sync_pulse = pulse_r;
    assign delay_adjust_one = dlya_r.delay_adjust_one;
    assign delay_adjust_two = dlya_r.delay_adjust_two;
    assign delay_adjust_three = dlyb_r.delay_adjust_three;
    assign delay_adjust_four = dlyb_r.delay_adjust_four;

    property p_no_pulse_disabled;
        @(posedge aclk) disable iff (!aresetn)
        !en && !$past(en) |-> !frame_sync_pulse;
    endproperty
    a_no_pulse_disabled: assert property (p_no_pulse_disabled)
        else $error("pulse while disabled");

    property p_repeater_idle;
        @(posedge aclk) disable iff (!aresetn)
        repeater && state_r == FSP_IDLE && !burst_trig |=> state_r != FSP_RUN;
    endproperty
    a_repeater_idle: assert property (p_repeater_idle)
        else $error("repeater ran continuously");

    property p_burst_start;
        @(posedge aclk) disable iff (!aresetn)
        state_r == FSP_IDLE && en && burst_trig |=> state_r == FSP_BURST;
    endproperty
    a_burst_start: assert property (p_burst_start)
        else $error("request did not start burst");

    property p_burst_load;
        @(posedge aclk) disable iff (!aresetn)
        state_r == FSP_IDLE |=> burst_left_r == $past(dlyb_r.burst_pulse_count);
    endproperty
    a_burst_load: assert property (p_burst_load)
        else $error("burst count not loaded");

    property p_reset_vals;
        @(posedge aclk)
        !aresetn |=> ctrl_r == FSP_RST_CTRL && dlya_r == FSP_RST_DLYA && div_r == FSP_RST_DIV;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    // the smallest prescale ratio is two, so two pulses can never be adjacent
    property p_pre_div2;
        @(posedge aclk) disable iff (!aresetn)
        frame_sync_pulse |=> !frame_sync_pulse;
    endproperty
    a_pre_div2: assert property (p_pre_div2)
        else $error("frame sync pulses back to back");

    property p_post_div;
        @(posedge aclk) disable iff (!aresetn)
        post_tick |-> post_cnt_r >= post_last;
    endproperty
    a_post_div: assert property (p_post_div)
        else $error("post divider early");

    // the smallest channel ratio is two, so two enables can never be adjacent
    property p_output_channel_divider_code;
        @(posedge aclk) disable iff (!aresetn)
        chan_clk_en |=> !chan_clk_en;
    endproperty
    a_output_channel_divider_code: assert property (p_output_channel_divider_code)
        else $error("channel enables back to back");
endmodule
`default_nettype wire

// ===== tb/fsp_conv_model.sv
// converter-side model: counts channel clock and frame-sync pulses and their spacing
`timescale 1ns/1ps
`default_nettype none
module fsp_conv_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic src_clk_en,
    input wire logic chan_clk_en,
    input wire logic frame_sync_pulse
);
    int fs_cnt, ch_cnt, fs_gap, ch_gap, fs_acc, ch_acc;
    logic src_d;
    // a pulse lags its counting edge by one cycle, so the delayed source is counted
    always @(posedge aclk) begin
        if (!aresetn) begin
            src_d <= 1'b0;
            fs_cnt = 0;
            ch_cnt = 0;
            fs_acc = 0;
            ch_acc = 0;
        end else begin
            fs_acc = fs_acc + int'(src_d);
            ch_acc = ch_acc + int'(src_d);
            if (frame_sync_pulse) begin
                fs_cnt = fs_cnt + 1;
                fs_gap = fs_acc;
                fs_acc = 0;
            end
            if (chan_clk_en) begin
                ch_cnt = ch_cnt + 1;
                ch_gap = ch_acc;
                ch_acc = 0;
            end
            src_d <= src_clk_en;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// testbench: register traffic, pulse rates, bursts and channel division
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fsp_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req, src_en;
    logic awready, wready, bvalid, arready, rvalid, ch_en, fs_pulse;
    logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_r;
    logic [5:0] d1, d2, d3, d4;
    logic [15:0] rnd = 16'h7649;
    logic [15:0] v;
    logic [2:0] pres [4];
    logic [10:0] dvs [4];
    logic [3:0] cnts [3];
    int err_total, checks, s;

    fsp_frame_sync i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .frame_sync_request_pin(req), .src_clk_en(src_en),
        .chan_clk_en(ch_en), .frame_sync_pulse(fs_pulse), .delay_adjust_one(d1),
        .delay_adjust_two(d2), .delay_adjust_three(d3), .delay_adjust_four(d4));
    fsp_conv_model i_conv (.aclk(aclk), .aresetn(aresetn), .src_clk_en(src_en),
        .chan_clk_en(ch_en), .frame_sync_pulse(fs_pulse));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic int ratio(input int c);
        int t[13] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192};
        return t[c];
    endfunction
    // unlisted prescaler codes act as four, a zero post divider as one
    function automatic int period(input logic [2:0] pre, input logic [10:0] dv);
        return (pre == FSP_PRE_DIV2 ? 2 : 4) * (dv == 11'h0 ? 1 : int'(dv));
    endfunction

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // the source rate is irregular on purpose so dividers must count enables, not cycles
    always @(posedge aclk) begin
        rnd <= lfsr(rnd);
        src_en <= rnd[0] | rnd[3];
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic timeout();
        err_total++;
        $display("ERROR wait expected done seen timeout");
        give_verdict();
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= {22'h0, idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= {16'h0, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) timeout();
        chk("bresp", 32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx);
        int n;
        @(posedge aclk);
        araddr <= {22'h0, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) timeout();
        rd_v = rdata;
        rd_r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [15:0] e);
        rd(idx);
        chk(nm, rd_v, {16'h0, e});
        chk("rresp", 32'(rd_r), 32'(FSP_RESP_OKAY));
    endtask
    task automatic wait_n(input logic sel, input int k);
        int n, s0;
        #1 s0 = sel ? i_conv.ch_cnt : i_conv.fs_cnt;
        for (n = 0; n < 40000; n++) begin
            @(posedge aclk);
            #1;
            if ((sel ? i_conv.ch_cnt : i_conv.fs_cnt) >= s0 + k) break;
        end
        if (n == 40000) timeout();
    endtask
    task automatic count_fs(input int cyc, output int d);
        int s0;
        // let a pulse launched by the old setting reach the model before counting
        repeat (2) @(posedge aclk);
        #1 s0 = i_conv.fs_cnt;
        repeat (cyc) @(posedge aclk);
        #1 d = i_conv.fs_cnt - s0;
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, req} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        aresetn = 1'b0;
        err_total = 0;
        checks = 0;
        pres = '{FSP_PRE_DIV2, FSP_PRE_DIV4, FSP_PRE_DIV4, FSP_PRE_DIV2};
        dvs = '{11'h001, 11'h001, 11'h005, 11'h7FF};
        cnts = '{4'h0, 4'h1, 4'hF};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk("dly one", 32'(d1), 32'h3F);
        chk("dly rest", 32'({d2, d3, d4}), 32'h0);
        rdchk("ctrl", FSP_IDX_CTRL, 16'h0080);
        rdchk("div", FSP_IDX_DIV, 16'h0001);
        rdchk("dlya", FSP_IDX_DLYA, 16'h003F);
        rdchk("dlyb", FSP_IDX_DLYB, 16'h0000);
        rdchk("output_channel_divider_code", FSP_IDX_OUTPUT_CHANNEL_DIVIDER_CODE, 16'h0800);
        rd(8'h50);
        chk("unmapped data", rd_v, 32'h0);
        chk("unmapped rresp", 32'(rd_r), 32'(FSP_RESP_SLVERR));
        wr(8'h50, 16'h1234, FSP_RESP_SLVERR);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = rnd & 16'h0FFF;
            wr(FSP_IDX_DLYA, v, FSP_RESP_OKAY);
            rdchk("dlya rw", FSP_IDX_DLYA, v);
            chk("dly one two", 32'({d2, d1}), 32'(v[11:0]));
            v = rnd;
            wr(FSP_IDX_DLYB, v, FSP_RESP_OKAY);
            rdchk("dlyb rw", FSP_IDX_DLYB, v);
            chk("dly three four", 32'({d4, d3}), 32'(v[11:0]));
        end
        $display("test registers done");
        wr(FSP_IDX_DIV, 16'h0001, FSP_RESP_OKAY);
        wr(FSP_IDX_CTRL, 16'h0040, FSP_RESP_OKAY);
        count_fs(300, s);
        chk("pulses when off", 32'(s), 32'h0);
        dvs[2] = 11'(rnd[3:0]) + 11'h002;
        for (int i = 0; i < 4; i++) begin
            wr(FSP_IDX_DIV, {5'h0, dvs[i]}, FSP_RESP_OKAY);
            wr(FSP_IDX_CTRL, {8'h0, pres[i], 5'b01000}, FSP_RESP_OKAY);
            wait_n(1'b0, 3);
            chk("fs period", 32'(i_conv.fs_gap), 32'(period(pres[i], dvs[i])));
        end
        $display("test continuous done");
        wr(FSP_IDX_DIV, 16'h0001, FSP_RESP_OKAY);
        // repeater mode first, then master mode with bursts enabled
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 3; k++) begin
                wr(FSP_IDX_DLYB, {cnts[k], 12'h0}, FSP_RESP_OKAY);
                wr(FSP_IDX_CTRL, m ? 16'h0058 : 16'h004C, FSP_RESP_OKAY);
                count_fs(60, s);
                chk("no request", 32'(s), 32'h0);
                #1 s = i_conv.fs_cnt;
                @(posedge aclk);
                req <= 1'b1;
                repeat (6) @(posedge aclk);
                req <= 1'b0;
                repeat (200) @(posedge aclk);
                #1 chk("burst", 32'(i_conv.fs_cnt - s), cnts[k] == 0 ? 32'h1 : 32'(cnts[k]));
            end
        end
        rdchk("status idle", FSP_IDX_STAT, 16'h001F);
        $display("test bursts done");
        for (int c = 0; c < 13; c++) begin
            wr(FSP_IDX_OUTPUT_CHANNEL_DIVIDER_CODE, 16'h0800 | 16'(c << 6), FSP_RESP_OKAY);
            wait_n(1'b1, 3);
            chk("chan ratio", 32'(i_conv.ch_gap), 32'(ratio(c)));
        end
        $display("test channel divider done");
        give_verdict();
    end
endmodule
`default_nettype wire
